// ==== acr_defs.svh ====
// register offsets, field positions, fixed values and reset values of the capability bank
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH
`define ACR_PWR_BUDGET_HDR_OFF 12'h20c
`define ACR_ACS_HDR_OFF 12'h220
`define ACR_ACS_CAP_OFF 12'h224
`define ACR_EGRESS_OFF 12'h228
`define ACR_LTR_HDR_OFF 12'h230
`define ACR_SNOOP_LAT_OFF 12'h234
`define ACR_ACS_CAP_ID 16'h000d
`define ACR_LTR_CAP_ID 16'h0018
`define ACR_PWR_CAP_ID 16'h0004
`define ACR_CAP_VERSION 4'h1
`define ACR_NEXT_END 12'h000
`define ACR_PWR_NEXT_UP 12'h230
`define ACR_PWR_NEXT_DOWN 12'h220
`define ACR_FEATURE_IMPL 7'h7f
`define ACR_EGRESS_SIZE 8'h08
`define ACR_ENABLE_LSB 16
`define ACR_SIZE_LSB 8
`define ACR_SCALE_LSB 10
`define ACR_ENABLE_RST 7'h00
`define ACR_EGRESS_RST 8'h00
`define ACR_SNOOP_VAL_RST 10'h000
`define ACR_SNOOP_SCALE_RST 3'h0
`endif

// ==== acr_pkg.sv ====
// shared types of the capability bank
package acr_pkg;
   // index of each ACS feature, same order in implemented and enable bits
   typedef enum logic [2:0] {
      ACR_SRC_VALID, ACR_XLATE_BLOCK, ACR_REQ_REDIR, ACR_CPL_REDIR,
      ACR_UP_FWD, ACR_EGRESS_CTRL, ACR_DIRECT_XLATE
   } acr_feature_type;
   // verdict on a peer-to-peer request
   typedef enum logic [1:0] {
      ACR_ROUTE_NORMAL, ACR_ROUTE_REDIRECT, ACR_ROUTE_BLOCK
   } acr_route_type;
endpackage

// ==== acr_egress_check.sv ====
// egress decision for one peer-to-peer request on a downstream port
`timescale 1ns/1ps
module acr_egress_check #(
   parameter int PORTS = 8
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [6:0] enable,
   input wire logic [PORTS-1:0] egress_vector,
   input wire logic req_valid,
   input wire logic [2:0] req_target,
   input wire logic req_is_cpl,
   output acr_pkg::acr_route_type route,
   output logic route_valid
);
   typedef struct packed {
      acr_pkg::acr_route_type route;
      logic valid;
   } acr_chk_state_type;
   acr_chk_state_type state_reg;
   acr_chk_state_type state_next;
   logic hit;
   logic redir_on;

   ////////////////////////////////////////////////////////////////////////
   // verdict: redirect wins, then egress block on a vector hit, else normal
   always_comb begin
      state_next = state_reg;
      hit = egress_vector[req_target];
      redir_on = req_is_cpl ? enable[acr_pkg::ACR_CPL_REDIR] : enable[acr_pkg::ACR_REQ_REDIR];
      state_next.valid = req_valid;
      if (req_valid) begin
         if (enable[acr_pkg::ACR_EGRESS_CTRL] && hit) begin
            state_next.route = redir_on ? acr_pkg::ACR_ROUTE_REDIRECT : acr_pkg::ACR_ROUTE_BLOCK;
         end else if (redir_on) begin
            state_next.route = acr_pkg::ACR_ROUTE_REDIRECT;
         end else begin
            state_next.route = acr_pkg::ACR_ROUTE_NORMAL;
         end
      end
      if (srst) begin
         state_next.route = acr_pkg::ACR_ROUTE_NORMAL;
         state_next.valid = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      state_reg <= state_next;
   end

   assign route = state_reg.route;
   assign route_valid = state_reg.valid;
endmodule

// ==== acr_cap_regs.sv ====
// ACS and LTR extended capability register bank of one switch port
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "acr_defs.svh"

// How it works
// - ACS header reads ID 000Dh, version 1, end
// - seven ACS feature bits read as one
// - egress vector size field reads 08h
// - seven ACS enables, read-write, reset zero
// - egress vector read-write, blocks peer traffic
// - LTR header reads ID 0018h, version 1, end
// - snoop latency value bits 9:0, reset zero
// - snoop latency scale bits 12:10, reset zero
// - ACS downstream only, LTR upstream only
// - power budget next pointer 230h or 220h
module acr_cap_regs #(
   parameter int EGRESS_PORTS = 8
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic is_upstream,
   input wire logic [11:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [31:0] rdata,
   output logic [6:0] acs_enable,
   output logic [EGRESS_PORTS-1:0] egress_vector,
   output logic [9:0] snoop_value,
   output logic [2:0] snoop_scale,
   input wire logic p2p_valid,
   input wire logic [2:0] p2p_target,
   input wire logic p2p_is_cpl,
   output acr_pkg::acr_route_type p2p_route,
   output logic p2p_route_valid
);
   typedef struct packed {
      logic [6:0] enable;
      logic [EGRESS_PORTS-1:0] egress;
      logic [9:0] snoop_val;
      logic [2:0] snoop_scale;
      logic [31:0] rdata;
   } acr_bank_state_type;

   acr_bank_state_type state_reg;
   acr_bank_state_type state_next;
   logic [31:0] read_word;
   logic [6:0] check_enable;

   ////////////////////////////////////////////////////////////////////////
   // decoding helpers; offset_present serves read and write paths, cap_header only the read path

   // a capability header word from its parts
   function automatic logic [31:0] cap_header(input logic [15:0] id, input logic [11:0] next_off);
      cap_header = {next_off, `ACR_CAP_VERSION, id};
   endfunction

   // true when the offset belongs to the structure this port implements
   function automatic logic offset_present(input logic [11:0] a, input logic up);
      logic acs_side;
      acs_side = (a == `ACR_ACS_HDR_OFF) || (a == `ACR_ACS_CAP_OFF) || (a == `ACR_EGRESS_OFF);
      // ACS only downstream, LTR only upstream
      if (acs_side) begin
         offset_present = !up;
      end else if ((a == `ACR_LTR_HDR_OFF) || (a == `ACR_SNOOP_LAT_OFF)) begin
         offset_present = up;
      end else begin
         offset_present = (a == `ACR_PWR_BUDGET_HDR_OFF);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // read mux; unmapped or absent offsets read zero
   always_comb begin
      read_word = 32'h0000_0000;
      if (!offset_present(addr, is_upstream)) begin
         read_word = 32'h0000_0000;
      end else if (addr == `ACR_PWR_BUDGET_HDR_OFF) begin
         // link into whichever structure this port has
         read_word = cap_header(`ACR_PWR_CAP_ID, is_upstream ? `ACR_PWR_NEXT_UP : `ACR_PWR_NEXT_DOWN);
      end else if (addr == `ACR_ACS_HDR_OFF) begin
         read_word = cap_header(`ACR_ACS_CAP_ID, `ACR_NEXT_END);
      end else if (addr == `ACR_ACS_CAP_OFF) begin
         read_word[6:0] = `ACR_FEATURE_IMPL;
         read_word[`ACR_SIZE_LSB +: 8] = `ACR_EGRESS_SIZE;
         read_word[`ACR_ENABLE_LSB +: 7] = state_reg.enable;
      end else if (addr == `ACR_EGRESS_OFF) begin
         read_word[EGRESS_PORTS-1:0] = state_reg.egress;
      end else if (addr == `ACR_LTR_HDR_OFF) begin
         read_word = cap_header(`ACR_LTR_CAP_ID, `ACR_NEXT_END);
      end else begin
         read_word[9:0] = state_reg.snoop_val;
         read_word[`ACR_SCALE_LSB +: 3] = state_reg.snoop_scale;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register updates; only writable fields are taken from wdata
   always_comb begin
      state_next = state_reg;
      state_next.rdata = rd_stb ? read_word : 32'h0000_0000;
      if (wr_stb && offset_present(addr, is_upstream)) begin
         if (addr == `ACR_ACS_CAP_OFF) begin
            // enables writable, bit 7 and 31:23 dropped
            state_next.enable = wdata[`ACR_ENABLE_LSB +: 7];
         end else if (addr == `ACR_EGRESS_OFF) begin
            state_next.egress = wdata[EGRESS_PORTS-1:0];
         end else if (addr == `ACR_SNOOP_LAT_OFF) begin
            state_next.snoop_val = wdata[9:0];
            state_next.snoop_scale = wdata[`ACR_SCALE_LSB +: 3];
         end
      end
      if (srst) begin
         state_next.enable = `ACR_ENABLE_RST;
         state_next.egress = '0;
         state_next.snoop_val = `ACR_SNOOP_VAL_RST;
         state_next.snoop_scale = `ACR_SNOOP_SCALE_RST;
         state_next.rdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge sys_clk) begin
      state_reg <= state_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs to the forwarding logic
   assign rdata = state_reg.rdata;
   assign acs_enable = state_reg.enable;
   assign egress_vector = state_reg.egress;
   assign snoop_value = state_reg.snoop_val;
   assign snoop_scale = state_reg.snoop_scale;

   // upstream port has no ACS, so no control acts there
   assign check_enable = is_upstream ? 7'h00 : state_reg.enable;

   // per-request egress verdict; a register stage keeps it off the bus timing
   acr_egress_check #(
      .PORTS(EGRESS_PORTS)
   ) u_check (
      .sys_clk(sys_clk),
      .srst(srst),
      .enable(check_enable),
      .egress_vector(state_reg.egress),
      .req_valid(p2p_valid),
      .req_target(p2p_target),
      .req_is_cpl(p2p_is_cpl),
      .route(p2p_route),
      .route_valid(p2p_route_valid)
   );

   ////////////////////////////////////////////////////////////////////////
   // checks
   AST_ACS_HDR: assert property (@(posedge sys_clk) disable iff (srst)
      rd_stb && !is_upstream && addr == `ACR_ACS_HDR_OFF |=> rdata == 32'h0001_000d)
      else $error("ACS header read wrong");
   AST_FEATURES: assert property (@(posedge sys_clk) disable iff (srst)
      rd_stb && !is_upstream && addr == `ACR_ACS_CAP_OFF |=> rdata[7:0] == 8'h7f)
      else $error("feature bits wrong");
   AST_SIZE: assert property (@(posedge sys_clk) disable iff (srst)
      rd_stb && !is_upstream && addr == `ACR_ACS_CAP_OFF |=> rdata[15:8] == 8'h08)
      else $error("vector size wrong");
   AST_ENABLE_WR: assert property (@(posedge sys_clk) disable iff (srst)
      wr_stb && !is_upstream && addr == `ACR_ACS_CAP_OFF
      |=> acs_enable == $past(wdata[`ACR_ENABLE_LSB +: 7]))
      else $error("enable write not read back");
   AST_EGRESS_RST: assert property (@(posedge sys_clk)
      $fell(srst) |-> egress_vector == 8'h00 && acs_enable == 7'h00)
      else $error("egress or enables not cleared by reset");
   AST_LTR_HDR: assert property (@(posedge sys_clk) disable iff (srst)
      rd_stb && is_upstream && addr == `ACR_LTR_HDR_OFF |=> rdata == 32'h0001_0018)
      else $error("LTR header read wrong");
   AST_SNOOP_WR: assert property (@(posedge sys_clk) disable iff (srst)
      wr_stb && is_upstream && addr == `ACR_SNOOP_LAT_OFF |=> snoop_value == $past(wdata[9:0]))
      else $error("snoop value not written");
   AST_SCALE_WR: assert property (@(posedge sys_clk) disable iff (srst)
      wr_stb && is_upstream && addr == `ACR_SNOOP_LAT_OFF |=> snoop_scale == $past(wdata[12:10]))
      else $error("snoop scale not written");
   AST_ABSENT: assert property (@(posedge sys_clk) disable iff (srst)
      rd_stb && is_upstream && addr == `ACR_EGRESS_OFF |=> rdata == 32'h0000_0000)
      else $error("ACS visible on upstream port");
   AST_PWR_NEXT: assert property (@(posedge sys_clk) disable iff (srst)
      rd_stb && addr == `ACR_PWR_BUDGET_HDR_OFF
      |=> rdata[31:20] == ($past(is_upstream) ? 12'h230 : 12'h220))
      else $error("power budget next pointer wrong");
   AST_RSVD: assert property (@(posedge sys_clk) disable iff (srst)
      rd_stb && addr == `ACR_SNOOP_LAT_OFF |=> rdata[31:13] == 19'h0)
      else $error("reserved bits not zero");
   AST_NO_ACS_NORMAL: assert property (@(posedge sys_clk) disable iff (srst)
      p2p_valid && acs_enable == 7'h00 |=> p2p_route_valid && p2p_route == acr_pkg::ACR_ROUTE_NORMAL)
      else $error("traffic altered with controls off");

   ////////////////////////////////////////////////////////////////////////
   // field level checks; reads compare against the register value one cycle back

   AST_EGRESS_WR: assert property (@(posedge sys_clk) disable iff (srst)
      wr_stb && !is_upstream && addr == `ACR_EGRESS_OFF
      |=> egress_vector == $past(wdata[EGRESS_PORTS-1:0]))
      else $error("egress write lost");

   AST_EGRESS_RD: assert property (@(posedge sys_clk) disable iff (srst)
      rd_stb && !is_upstream && addr == `ACR_EGRESS_OFF
      |=> rdata[EGRESS_PORTS-1:0] == $past(egress_vector))
      else $error("egress read wrong");

   AST_EGRESS_RSVD: assert property (@(posedge sys_clk) disable iff (srst)
      rd_stb && !is_upstream && addr == `ACR_EGRESS_OFF
      |=> (rdata >> EGRESS_PORTS) == 32'h0000_0000)
      else $error("egress reserved bits set");

   AST_ENABLE_RD: assert property (@(posedge sys_clk) disable iff (srst)
      rd_stb && !is_upstream && addr == `ACR_ACS_CAP_OFF
      |=> rdata[22:16] == $past(acs_enable))
      else $error("enable read wrong");

   AST_CAP_RSVD: assert property (@(posedge sys_clk) disable iff (srst)
      rd_stb && !is_upstream && addr == `ACR_ACS_CAP_OFF
      |=> rdata[31:23] == 9'h000 && !rdata[7])
      else $error("capability reserved bits set");

   AST_ENABLE_RST: assert property (@(posedge sys_clk)
      srst
      |=> acs_enable == 7'h00)
      else $error("enables not cleared");

   AST_SNOOP_RST: assert property (@(posedge sys_clk)
      srst
      |=> snoop_value == 10'h000)
      else $error("snoop value not cleared");

   AST_SCALE_RST: assert property (@(posedge sys_clk)
      srst
      |=> snoop_scale == 3'h0)
      else $error("snoop scale not cleared");

   AST_LTR_ABSENT: assert property (@(posedge sys_clk) disable iff (srst)
      rd_stb && !is_upstream && addr == `ACR_LTR_HDR_OFF
      |=> rdata == 32'h0000_0000)
      else $error("LTR visible downstream");

   AST_SNOOP_LOCKED: assert property (@(posedge sys_clk) disable iff (srst)
      wr_stb && !is_upstream && addr == `ACR_SNOOP_LAT_OFF
      |=> snoop_value == $past(snoop_value) && snoop_scale == $past(snoop_scale))
      else $error("snoop written downstream");

   AST_ACS_LOCKED: assert property (@(posedge sys_clk) disable iff (srst)
      wr_stb && is_upstream && addr == `ACR_ACS_CAP_OFF
      |=> acs_enable == $past(acs_enable))
      else $error("enables written upstream");

   AST_SNOOP_RD: assert property (@(posedge sys_clk) disable iff (srst)
      rd_stb && is_upstream && addr == `ACR_SNOOP_LAT_OFF
      |=> rdata[9:0] == $past(snoop_value))
      else $error("snoop value read wrong");

   AST_SCALE_RD: assert property (@(posedge sys_clk) disable iff (srst)
      rd_stb && is_upstream && addr == `ACR_SNOOP_LAT_OFF
      |=> rdata[12:10] == $past(snoop_scale))
      else $error("snoop scale read wrong");

   AST_UP_NORMAL: assert property (@(posedge sys_clk) disable iff (srst)
      p2p_valid && is_upstream
      |=> p2p_route_valid && p2p_route == acr_pkg::ACR_ROUTE_NORMAL)
      else $error("upstream traffic altered");

   AST_BLOCK: assert property (@(posedge sys_clk) disable iff (srst)
      p2p_valid && !is_upstream && acs_enable[5] && egress_vector[p2p_target]
      && !(p2p_is_cpl ? acs_enable[3] : acs_enable[2])
      |=> p2p_route == acr_pkg::ACR_ROUTE_BLOCK)
      else $error("egress hit not blocked");

   AST_REDIRECT: assert property (@(posedge sys_clk) disable iff (srst)
      p2p_valid && !is_upstream && (p2p_is_cpl ? acs_enable[3] : acs_enable[2])
      |=> p2p_route == acr_pkg::ACR_ROUTE_REDIRECT)
      else $error("redirect not applied");

   AST_NO_BLOCK: assert property (@(posedge sys_clk) disable iff (srst)
      p2p_valid && !(acs_enable[5] && egress_vector[p2p_target])
      |=> p2p_route != acr_pkg::ACR_ROUTE_BLOCK)
      else $error("block without egress hit");

   AST_ROUTE_PULSE: assert property (@(posedge sys_clk) disable iff (srst)
      !p2p_valid
      |=> !p2p_route_valid)
      else $error("verdict without request");

   AST_PWR_ID: assert property (@(posedge sys_clk) disable iff (srst)
      rd_stb && addr == `ACR_PWR_BUDGET_HDR_OFF
      |=> rdata[19:0] == 20'h1_0004)
      else $error("power budget id wrong");

   AST_RDATA_IDLE: assert property (@(posedge sys_clk) disable iff (srst)
      !rd_stb
      |=> rdata == 32'h0000_0000)
      else $error("read data without read");

   AST_EGRESS_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
      !wr_stb
      |=> egress_vector == $past(egress_vector))
      else $error("egress changed without write");

   AST_ENABLE_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
      !wr_stb
      |=> acs_enable == $past(acs_enable))
      else $error("enables changed without write");

   AST_SNOOP_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
      !wr_stb
      |=> snoop_value == $past(snoop_value) && snoop_scale == $past(snoop_scale))
      else $error("latency changed without write");

   for (genvar i = 0; i < 7; i++) begin : g_en_chk
      AST_EN_BIT: assert property (@(posedge sys_clk) disable iff (srst)
         wr_stb && !is_upstream && addr == `ACR_ACS_CAP_OFF
         |=> acs_enable[i] == $past(wdata[`ACR_ENABLE_LSB + i]))
         else $error("enable bit not written");
   end
endmodule

// ==== acr_cap_regs_tb.sv ====
// self-checking bench for the capability register bank
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic up;
      logic [11:0] addr;
      logic [31:0] wdata;
      logic [31:0] exp;
   } acr_tb_row_type;
   logic sys_clk = 1'h0;
   logic srst = 1'h1;
   logic is_upstream = 1'h0;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic wr_stb = 1'h0;
   logic rd_stb = 1'h0;
   logic [31:0] rdata;
   logic [6:0] acs_enable;
   logic [7:0] egress_vector;
   logic [9:0] snoop_value;
   logic [2:0] snoop_scale;
   logic p2p_valid = 1'h0;
   logic [2:0] p2p_target = 3'h0;
   logic p2p_is_cpl = 1'h0;
   acr_pkg::acr_route_type p2p_route;
   logic p2p_route_valid;
   int miscompares = 0;
   int cmp_count = 0;
   acr_tb_row_type rows [14];

   acr_cap_regs #(.EGRESS_PORTS(8)) acr_cap_regs_i (.sys_clk(sys_clk), .srst(srst), .is_upstream(is_upstream),
      .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .acs_enable(acs_enable),
      .egress_vector(egress_vector), .snoop_value(snoop_value), .snoop_scale(snoop_scale), .p2p_valid(p2p_valid),
      .p2p_target(p2p_target), .p2p_is_cpl(p2p_is_cpl), .p2p_route(p2p_route), .p2p_route_valid(p2p_route_valid));

////////////////////////////////////////////////////////////////////////////////
   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;

   // one comparison; unknowns never match
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // verdict and end of run, also reached from the watchdog
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // port kind only changes under reset, since the design treats it as static
   task automatic do_reset(input logic up);
      @(posedge sys_clk);
      srst <= 1'h1;
      is_upstream <= up;
      repeat (12) @(posedge sys_clk);
      srst <= 1'h0;
      #1;
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'h1;
      @(posedge sys_clk);
      wr_stb <= 1'h0;
      // let the write settle before any output is looked at
      #1;
   endtask

   // read data stand only in the cycle after the strobe, zero after that
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      addr <= a;
      rd_stb <= 1'h1;
      @(posedge sys_clk);
      rd_stb <= 1'h0;
      #1;
      check("rdata", exp, rdata);
      @(posedge sys_clk);
      #1;
      check("rdata idle", 32'h0, rdata);
   endtask

   // one peer request, verdict a cycle later
   task automatic judge(input logic [2:0] t, input logic cpl, input acr_pkg::acr_route_type exp);
      @(posedge sys_clk);
      p2p_valid <= 1'h1;
      p2p_target <= t;
      p2p_is_cpl <= cpl;
      @(posedge sys_clk);
      p2p_valid <= 1'h0;
      #1;
      check("route_valid", 32'h1, 32'(p2p_route_valid));
      check("route", 32'(exp), 32'(p2p_route));
   endtask

////////////////////////////////////////////////////////////////////////////////
   // watchdog: a hang counts as a mismatch
   initial begin
      #200000;
      miscompares++;
      wrap_up();
   end

   // main sequence: table of write-then-read rows, then hand-written cases
   initial begin
      rows = '{
         '{1'h0, 12'h220, 32'hffffffff, 32'h0001000d},
         '{1'h0, 12'h224, 32'hffffffff, 32'h007f087f},
         '{1'h0, 12'h228, 32'hffffffff, 32'h000000ff},
         '{1'h0, 12'h228, 32'h000000a5, 32'h000000a5},
         '{1'h0, 12'h230, 32'hffffffff, 32'h00000000},
         '{1'h0, 12'h234, 32'hffffffff, 32'h00000000},
         '{1'h0, 12'h20c, 32'hffffffff, 32'h22010004},
         '{1'h0, 12'h23c, 32'hffffffff, 32'h00000000},
         '{1'h1, 12'h224, 32'hffffffff, 32'h00000000},
         '{1'h1, 12'h230, 32'hffffffff, 32'h00010018},
         '{1'h1, 12'h234, 32'hffffffff, 32'h00001fff},
         '{1'h1, 12'h234, 32'h00001555, 32'h00001555},
         '{1'h1, 12'h20c, 32'hffffffff, 32'h23010004},
         '{1'h1, 12'h220, 32'hffffffff, 32'h00000000}
      };
      do_reset(1'h0);
      for (int i = 0; i < 14; i++) begin
         if (rows[i].up !== is_upstream) begin
            do_reset(rows[i].up);
         end
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, rows[i].exp);
      end
      // latency fields drive their outputs; upstream always routes peer traffic normally
      check("snoop_value", 32'h155, 32'(snoop_value));
      check("snoop_scale", 32'h5, 32'(snoop_scale));
      judge(3'h0, 1'h0, acr_pkg::ACR_ROUTE_NORMAL);
      // third reset in mid-run clears the latency fields
      do_reset(1'h1);
      check("snoop_value rst", 32'h0, 32'(snoop_value));
      check("snoop_scale rst", 32'h0, 32'(snoop_scale));
      rd(12'h234, 32'h0);
      // downstream reset values
      do_reset(1'h0);
      check("acs_enable rst", 32'h0, 32'(acs_enable));
      check("egress rst", 32'h0, 32'(egress_vector));
      rd(12'h224, 32'h0000087f);
      // egress control alone blocks targets whose vector bit is set
      wr(12'h228, 32'h00000005);
      wr(12'h224, 32'h00200000);
      check("acs_enable", 32'h20, 32'(acs_enable));
      check("egress_vector", 32'h05, 32'(egress_vector));
      judge(3'h0, 1'h0, acr_pkg::ACR_ROUTE_BLOCK);
      judge(3'h1, 1'h0, acr_pkg::ACR_ROUTE_NORMAL);
      judge(3'h2, 1'h1, acr_pkg::ACR_ROUTE_BLOCK);
      // request redirect turns a block into a redirect, completions stay blocked
      wr(12'h224, 32'h00240000);
      judge(3'h0, 1'h0, acr_pkg::ACR_ROUTE_REDIRECT);
      judge(3'h0, 1'h1, acr_pkg::ACR_ROUTE_BLOCK);
      // completion redirect alone
      wr(12'h224, 32'h00080000);
      judge(3'h1, 1'h1, acr_pkg::ACR_ROUTE_REDIRECT);
      judge(3'h1, 1'h0, acr_pkg::ACR_ROUTE_NORMAL);
      // all enables off: vector still set but ignored
      wr(12'h224, 32'h00000000);
      judge(3'h0, 1'h0, acr_pkg::ACR_ROUTE_NORMAL);
      wrap_up();
   end
endmodule
